// File: design/flash_bus_host.v
// Summary of operation
// - Host presents a full 22-bit word address on every read and write.
// - Host issues each program bus cycle as its own request; the user sends the four, or two in bypass mode.
// - Protect: reset at unlock voltage, select and strobe low, A6 low, A1 high, A0 low.
// - Unprotect: same levels but A6 high.
// - Read: select and output gate low, write strobe high.
// - Write: strobe and select low, output gate high.
`include "flash_host_defines.vh"
module flash_bus_host #(
    parameter AW = `ADDR_W,
    parameter DW = `DATA_W,
    parameter PROG_US = `T_PROG_MAX_US,
    parameter ACC_PROG_US = `T_ACC_PROG_MAX_US,
    parameter BUSY_CYC = 32'd26250
) (
    // Clock and reset
    input wire CORE_CLK_I,
    input wire RST_B_I,
    // User command port
    input wire REQ_VALID_I,
    input wire [2:0] REQ_OP_I,
    input wire [AW-1:0] REQ_ADDR_I,
    input wire [DW-1:0] REQ_DATA_I,
    input wire REQ_ACCEL_I,
    input wire REQ_WAIT_I,
    input wire PROTECT_ACCEL_LVL_I,
    output wire REQ_READY_O,
    output reg RSP_VALID_O,
    output reg [DW-1:0] RSP_DATA_O,
    output reg RSP_TIMEOUT_O,
    // Flash pins
    output reg [AW-1:0] FL_ADDR_O,
    input wire [DW-1:0] FL_DATA_I,
    output reg [DW-1:0] FL_DATA_O,
    output reg FL_DATA_OE_O,
    output reg FL_CE_B_O,
    output reg FL_OE_B_O,
    output reg FL_WE_B_O,
    output reg FL_RESET_B_O,
    output reg FL_RESET_UNLOCK_O,
    output reg FL_PROTECT_ACCEL_O,
    output reg FL_ACCEL_HV_O,
    input wire FL_READY_I
);
    ////////////////////////////////////////////////////////////////////////
    localparam [5:0] S_IDLE = 6'h01;
    localparam [5:0] S_STROBE = 6'h02;
    localparam [5:0] S_HOLD = 6'h04;
    localparam [5:0] S_READ = 6'h08;
    localparam [5:0] S_RST = 6'h10;
    localparam [5:0] S_BUSY = 6'h20;
    localparam [31:0] PROG_CYC = PROG_US * `CYC_PER_US;
    localparam [31:0] ACC_CYC = ACC_PROG_US * `CYC_PER_US;
    reg [5:0] state_q;
    reg [2:0] op_q;
    reg wait_q;
    reg load;
    reg [31:0] load_val;
    wire done;
    ////////////////////////////////////////////////////////////////////////
    // One counter serves pulse widths and the busy-wait timeout
    flash_tick_counter #(.W(32)) u_cnt (
        .clk_i(CORE_CLK_I),
        .rst_b_i(RST_B_I),
        .load_i(load),
        .count_i(load_val),
        .tick_i(1'b1),
        .done_o(done)
    );
    assign REQ_READY_O = (state_q == S_IDLE);
    always @* begin
        load = 1'b0;
        load_val = 32'h0;
        case (state_q)
            S_IDLE: begin
                if (REQ_VALID_I) begin
                    load = 1'b1;
                    case (REQ_OP_I)
                        `OP_READ: load_val = `CYC_ACC;
                        `OP_RESET: load_val = `CYC_RP;
                        `OP_PROTECT, `OP_UNPROTECT: load_val = `CYC_PROT;
                        default: load_val = `CYC_WP;
                    endcase
                end
            end
            S_STROBE: begin
                if (done) begin
                    load = 1'b1;
                    load_val = (op_q == `OP_RESET) ? `CYC_RH : `CYC_WPH;
                end
            end
            S_HOLD: begin
                // Timeout covers the worst program time (accelerated or not), bus overhead apart; erase times are not covered
                if (done && wait_q) begin
                    load = 1'b1;
                    load_val = FL_ACCEL_HV_O ? ACC_CYC : PROG_CYC;
                    if (op_q != `OP_WRITE) begin
                        load_val = BUSY_CYC;
                    end
                end
            end
            default: begin
                load = 1'b0;
                load_val = 32'h0;
            end
        endcase
    end
    ////////////////////////////////////////////////////////////////////////
    always @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state_q <= S_IDLE;
            op_q <= 3'h0;
            wait_q <= 1'b0;
            RSP_VALID_O <= 1'b0;
            RSP_DATA_O <= {DW{1'b0}};
            RSP_TIMEOUT_O <= 1'b0;
            FL_ADDR_O <= {AW{1'b0}};
            FL_DATA_O <= {DW{1'b0}};
            FL_DATA_OE_O <= 1'b0;
            FL_CE_B_O <= 1'b1;
            FL_OE_B_O <= 1'b1;
            FL_WE_B_O <= 1'b1;
            FL_RESET_B_O <= 1'b1;
            FL_RESET_UNLOCK_O <= 1'b0;
            FL_PROTECT_ACCEL_O <= 1'b0;
            FL_ACCEL_HV_O <= 1'b0;
        end else begin
            RSP_VALID_O <= 1'b0;
            FL_PROTECT_ACCEL_O <= PROTECT_ACCEL_LVL_I;
            case (state_q)
                S_IDLE: begin
                    if (REQ_VALID_I) begin
                        op_q <= REQ_OP_I;
                        wait_q <= REQ_WAIT_I;
                        RSP_TIMEOUT_O <= 1'b0;
                        FL_ADDR_O <= REQ_ADDR_I;
                        FL_ACCEL_HV_O <= REQ_ACCEL_I;
                        state_q <= S_STROBE;
                        case (REQ_OP_I)
                            `OP_READ: begin
                                FL_CE_B_O <= 1'b0;
                                FL_OE_B_O <= 1'b0;
                            end
                            `OP_RESET: begin
                                FL_RESET_B_O <= 1'b0;
                                FL_CE_B_O <= 1'b1;
                            end
                            `OP_PROTECT, `OP_UNPROTECT: begin
                                FL_ADDR_O[`PROT_A6_BIT] <= (REQ_OP_I == `OP_UNPROTECT);
                                FL_ADDR_O[`PROT_A1_BIT] <= 1'b1;
                                FL_ADDR_O[`PROT_A0_BIT] <= 1'b0;
                                FL_RESET_UNLOCK_O <= 1'b1;
                                FL_DATA_O <= REQ_DATA_I;
                                FL_DATA_OE_O <= 1'b1;
                                FL_CE_B_O <= 1'b0;
                                FL_WE_B_O <= 1'b0;
                            end
                            default: begin
                                // Address and data settle with the strobe edge
                                FL_DATA_O <= REQ_DATA_I;
                                FL_DATA_OE_O <= 1'b1;
                                FL_CE_B_O <= 1'b0;
                                FL_WE_B_O <= 1'b0;
                            end
                        endcase
                    end
                end
                S_STROBE: begin
                    if (done) begin
                        if (op_q == `OP_READ) begin
                            RSP_DATA_O <= FL_DATA_I;
                            RSP_VALID_O <= 1'b1;
                            FL_OE_B_O <= 1'b1;
                            FL_CE_B_O <= 1'b1;
                            state_q <= S_IDLE;
                        end else if (op_q == `OP_RESET) begin
                            // Device comes back in array read; no command follows
                            FL_RESET_B_O <= 1'b1;
                            state_q <= S_RST;
                        end else begin
                            // Strobe and select rise together; data stays driven past them
                            FL_WE_B_O <= 1'b1;
                            FL_CE_B_O <= 1'b1;
                            state_q <= S_HOLD;
                        end
                    end
                end
                S_HOLD: begin
                    if (done) begin
                        FL_DATA_OE_O <= 1'b0;
                        FL_RESET_UNLOCK_O <= 1'b0;
                        // Each program cycle of a 2- or 4-cycle sequence is one request
                        if (wait_q) begin
                            state_q <= S_BUSY;
                        end else begin
                            RSP_VALID_O <= 1'b1;
                            state_q <= S_IDLE;
                        end
                    end
                end
                S_RST: begin
                    if (done) begin
                        RSP_VALID_O <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
                S_BUSY: begin
                    if (FL_READY_I || done) begin
                        RSP_TIMEOUT_O <= !FL_READY_I;
                        RSP_VALID_O <= 1'b1;
                        FL_ACCEL_HV_O <= 1'b0;
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule // flash_bus_host

// File: design/flash_host_defines.vh
`ifndef FLASH_HOST_DEFINES_VH
`define FLASH_HOST_DEFINES_VH
// Bus width and address width in word configuration
`define ADDR_W 22
`define DATA_W 16
// Protect / unprotect address bit positions
`define PROT_A6_BIT 6
`define PROT_A1_BIT 1
`define PROT_A0_BIT 0
// Host operation codes
`define OP_READ 3'h0
`define OP_WRITE 3'h1
`define OP_PROTECT 3'h2
`define OP_UNPROTECT 3'h3
`define OP_RESET 3'h4
// Clock rate and pin timing
`define CLK_MHZ 125
`define T_WP_NS 40
`define T_WPH_NS 25
`define T_ACC_NS 70
`define T_RP_NS 500
`define T_RH_NS 50
`define T_PROT_NS 100
// Embedded operation worst case times
`define T_PROG_MAX_US 210
`define T_ACC_PROG_MAX_US 120
`define T_SECT_ERASE_MAX_MS 5000
`define T_CHIP_ERASE_MAX_MS 216000
// Cycles: least times round up, a least of one
`define CYC_WP ((`T_WP_NS * `CLK_MHZ + 999) / 1000)
`define CYC_WPH ((`T_WPH_NS * `CLK_MHZ + 999) / 1000)
`define CYC_ACC ((`T_ACC_NS * `CLK_MHZ + 999) / 1000)
`define CYC_RP ((`T_RP_NS * `CLK_MHZ + 999) / 1000)
`define CYC_RH ((`T_RH_NS * `CLK_MHZ + 999) / 1000)
`define CYC_PROT ((`T_PROT_NS * `CLK_MHZ + 999) / 1000)
`define CYC_PER_US `CLK_MHZ
`endif

// File: design/flash_tick_counter.v
`include "flash_host_defines.vh"
module flash_tick_counter #(
    parameter W = 16
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // Control
    input wire load_i,
    input wire [W-1:0] count_i,
    input wire tick_i,
    // Status
    output wire done_o
);
    reg [W-1:0] cnt_q;
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q <= {W{1'b0}};
        end else if (load_i) begin
            cnt_q <= count_i;
        end else if (tick_i && cnt_q != {W{1'b0}}) begin
            cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        end
    end
    assign done_o = (cnt_q == {W{1'b0}});
endmodule // flash_tick_counter

// File: verif/flash_bus_host_assertions.sv
`include "flash_host_defines.vh"
module flash_bus_host_checker #(
    parameter AW = 22,
    parameter DW = 16
) (
    input wire CORE_CLK_I,
    input wire RST_B_I,
    input wire REQ_VALID_I,
    input wire REQ_READY_O,
    input wire [2:0] REQ_OP_I,
    input wire [AW-1:0] REQ_ADDR_I,
    input wire [DW-1:0] REQ_DATA_I,
    input wire PROTECT_ACCEL_LVL_I,
    input wire RSP_VALID_O,
    input wire [AW-1:0] FL_ADDR_O,
    input wire [DW-1:0] FL_DATA_O,
    input wire FL_DATA_OE_O,
    input wire FL_CE_B_O,
    input wire FL_OE_B_O,
    input wire FL_WE_B_O,
    input wire FL_RESET_B_O,
    input wire FL_RESET_UNLOCK_O,
    input wire FL_PROTECT_ACCEL_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_B_I);
    wire take = REQ_VALID_I && REQ_READY_O;
    a_write_launch:
        assert property (take && REQ_OP_I == `OP_WRITE |=> !FL_WE_B_O && !FL_CE_B_O && FL_OE_B_O
            && FL_DATA_OE_O && FL_ADDR_O == $past(REQ_ADDR_I) && FL_DATA_O == $past(REQ_DATA_I))
        else $error("write cycle launch wrong");
    a_read_levels:
        assert property (!FL_OE_B_O |-> FL_WE_B_O && !FL_CE_B_O && !FL_DATA_OE_O)
        else $error("read levels wrong");
    a_strobe_width:
        assert property ($fell(FL_WE_B_O) |-> (!FL_WE_B_O && !FL_CE_B_O) [*5])
        else $error("write strobe too short");
    a_read_answer:
        assert property (take && REQ_OP_I == `OP_READ |-> ##[9:12] RSP_VALID_O)
        else $error("read answer late");
    a_protect_levels:
        assert property (take && REQ_OP_I == `OP_PROTECT |=> FL_RESET_UNLOCK_O
            && !FL_WE_B_O && !FL_CE_B_O && FL_OE_B_O && FL_ADDR_O[1:0] == 2'h2 && !FL_ADDR_O[6])
        else $error("protect levels wrong");
    a_unprotect_levels:
        assert property (take && REQ_OP_I == `OP_UNPROTECT |=> FL_RESET_UNLOCK_O
            && !FL_WE_B_O && !FL_CE_B_O && FL_OE_B_O && FL_ADDR_O[1:0] == 2'h2 && FL_ADDR_O[6])
        else $error("unprotect levels wrong");
    a_reset_pulse:
        assert property (take && REQ_OP_I == `OP_RESET |-> ##2 (!FL_RESET_B_O && FL_CE_B_O) [*8])
        else $error("reset pulse wrong");
    a_pin_copy:
        assert property ($past(RST_B_I) |-> FL_PROTECT_ACCEL_O == $past(PROTECT_ACCEL_LVL_I))
        else $error("protect pin level not copied");
    a_answer_pulse:
        assert property (RSP_VALID_O |=> !RSP_VALID_O && REQ_READY_O)
        else $error("answer not one cycle");
endmodule // flash_bus_host_checker
bind flash_bus_host flash_bus_host_checker #(.AW(AW), .DW(DW)) chk (.*);

// File: verif/flash_die_model.sv
module flash_die_model (
    input wire clk_i,
    input wire [21:0] addr_i,
    input wire [15:0] data_i,
    input wire ce_b_i,
    input wire oe_b_i,
    input wire we_b_i,
    input wire reset_b_i,
    input wire unlock_i,
    input wire protect_accel_i,
    input wire accel_hv_i,
    input wire stall_i,
    output logic [15:0] data_o,
    output wire ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] PROG_SETUP = 16'h00a0;
    logic [15:0] mem_q [16];
    logic [15:0] cmd_q = 16'h0000;
    logic [15:0] last_q = 16'h0000;
    int busy_q = 0;
    wire boot = addr_i[21:13] == 9'h000 || &addr_i[21:13];
    wire wr_on = !ce_b_i && !we_b_i && reset_b_i;
    logic wr_q = 1'b0;
    initial foreach (mem_q[i]) mem_q[i] = 16'hffff;
    assign ready_o = busy_q == 0;
    ////////////////////////////////////////////////////////////////////////////////
    // Hidden latch: never readable, only steers the next write
    // A cycle ends at the first edge that sees select or strobe high; both may rise at once
    always @(posedge clk_i) begin
        wr_q <= wr_on;
        if (!reset_b_i) begin
            busy_q <= 0;
        end else if (wr_q && !wr_on) begin
            if (!unlock_i) begin
                if (cmd_q == PROG_SETUP && (protect_accel_i || !boot)) begin
                    mem_q[addr_i[3:0]] <= data_i;
                end
                cmd_q <= data_i;
            end
            busy_q <= stall_i ? 5000 : accel_hv_i ? 20 : 200;
        end else if (busy_q > 0) begin
            busy_q <= busy_q - 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Released lines toggle so a stale value never passes for data
    always_comb begin
        if (!ce_b_i && !oe_b_i && we_b_i && reset_b_i) data_o = mem_q[addr_i[3:0]];
        else data_o = ~last_q;
    end
    always @(posedge clk_i) last_q <= data_o;
endmodule // flash_die_model

// File: verif/test_flash_bus_host.sv
`include "flash_host_defines.vh"
module test_flash_bus_host;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_b = 0, valid = 0, accel = 0, wt = 0, pa_lvl = 1, stall = 0;
    logic [2:0] op = 3'h0;
    logic [21:0] addr = 22'h000000;
    logic [15:0] wdata = 16'h0000;
    wire ready, rsp_valid, rsp_to, oe, ce_b, oe_b, we_b, rb, unl, pa, hv, rdy;
    wire [15:0] rsp_data, fdo, die_q;
    wire [21:0] fa;
    wire [15:0] bus = oe ? fdo : die_q;
    int fails = 0, samples_checked = 0, cycles = 0;
    always #4 clk = ~clk;
    flash_bus_host #(.PROG_US(2), .ACC_PROG_US(1), .BUSY_CYC(32'd16)) uut (
        .CORE_CLK_I(clk), .RST_B_I(rst_b), .REQ_VALID_I(valid), .REQ_OP_I(op),
        .REQ_ADDR_I(addr), .REQ_DATA_I(wdata), .REQ_ACCEL_I(accel), .REQ_WAIT_I(wt),
        .PROTECT_ACCEL_LVL_I(pa_lvl), .REQ_READY_O(ready), .RSP_VALID_O(rsp_valid),
        .RSP_DATA_O(rsp_data), .RSP_TIMEOUT_O(rsp_to), .FL_ADDR_O(fa), .FL_DATA_I(bus),
        .FL_DATA_O(fdo), .FL_DATA_OE_O(oe), .FL_CE_B_O(ce_b), .FL_OE_B_O(oe_b),
        .FL_WE_B_O(we_b), .FL_RESET_B_O(rb), .FL_RESET_UNLOCK_O(unl),
        .FL_PROTECT_ACCEL_O(pa), .FL_ACCEL_HV_O(hv), .FL_READY_I(rdy));
    flash_die_model die (.clk_i(clk), .addr_i(fa), .data_i(bus), .ce_b_i(ce_b), .oe_b_i(oe_b),
        .we_b_i(we_b), .reset_b_i(rb), .unlock_i(unl), .protect_accel_i(pa), .accel_hv_i(hv),
        .stall_i(stall), .data_o(die_q), .ready_o(rdy));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("fails %0d samples_checked %0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Held one edge only: ready is high whenever the previous answer has come
    task automatic issue(input logic [2:0] o, input logic [21:0] a, input logic [15:0] d,
                         input logic w);
        int n;
        n = 0;
        @(posedge clk);
        #1 valid = 1;
        op = o;
        addr = a;
        wdata = d;
        wt = w;
        @(posedge clk);
        #1 valid = 0;
        while (rsp_valid !== 1'b1 && n < 6000) begin
            @(posedge clk);
            #1 n++;
        end
        check("answer", 16'h0001, {15'h0, rsp_valid});
    endtask
    task automatic prog(input logic [21:0] a, input logic [15:0] d, input logic [15:0] exp_to);
        issue(`OP_WRITE, 22'h200555, 16'h00a0, 1'b0);
        issue(`OP_WRITE, a, d, 1'b1);
        check("timeout", exp_to, {15'h0, rsp_to});
    endtask
    task automatic read_expect(input logic [21:0] a, input logic [15:0] exp);
        issue(`OP_READ, a, 16'h0000, 1'b0);
        check("read", exp, rsp_data);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_program;
        read_expect(22'h200003, 16'hffff);
        prog(22'h3fe006, 16'h1234, 16'h0000);
        read_expect(22'h3fe006, 16'h1234);
    endtask
    task automatic t_timeout_accel;
        stall = 1;
        prog(22'h200009, 16'h5555, 16'h0001);
        stall = 0;
        accel = 1;
        prog(22'h20000a, 16'haaaa, 16'h0000);
        accel = 0;
        read_expect(22'h20000a, 16'haaaa);
    endtask
    task automatic t_boot_lock;
        pa_lvl = 0;
        prog(22'h000007, 16'hbeef, 16'h0000);
        read_expect(22'h000007, 16'hffff);
        pa_lvl = 1;
        prog(22'h3fe008, 16'h0bad, 16'h0000);
        read_expect(22'h3fe008, 16'h0bad);
    endtask
    task automatic t_protect_reset;
        // A stuck device must end a waited protect by the short timeout
        stall = 1;
        issue(`OP_PROTECT, 22'h000002, 16'h0000, 1'b1);
        check("timeout", 16'h0001, {15'h0, rsp_to});
        stall = 0;
        issue(`OP_PROTECT, 22'h000002, 16'h0000, 1'b0);
        issue(`OP_UNPROTECT, 22'h000042, 16'h0000, 1'b0);
        issue(`OP_RESET, 22'h000000, 16'h0000, 1'b0);
        read_expect(22'h3fe006, 16'h1234);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) if (++cycles == 40000) begin
        fails++;
        tally_and_finish;
    end
    initial begin
        repeat (3) @(posedge clk);
        #1 rst_b = 1;
        t_program;
        t_timeout_accel;
        t_boot_lock;
        t_protect_reset;
        tally_and_finish;
    end
endmodule // test_flash_bus_host
